// ### src/ocm_ctrl.sv
// command, page sequencing and event flag logic for the OTP / config EEPROM
//
// Function
// - bit 15 enters program state until reset
// - protected fields change only when key unlocked
// - bit 13 selects EEPROM(0) or OTP(1), resets 1
// - bit 10 launches verify of selected pages
// - bit 9 launches OTP page programming
// - bit 8 launches read of selected pages
// - bit 11 finalises; later finalised writes fail
// - bits 7:6 set sense margin level
// - bit 5 selects single page or all
// - OTP page field picks pages 0 to 3
// - EEPROM page field maps to pages 2-4
// - done flag on command or auto-program end
// - fail flag on EEPROM read, verify, finalised-write errors
// - flags rise-set, cleared by writing one
// - unmasked set flag drives memory interrupt
// - masks block flags, both reset to one
// - commands only after program state entered
// - read copies pages into register window
// - verify compares OTP against register window
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
module ocm_ctrl
  import ocm_pkg::*;
(
  input  wire logic              I_SYS_CLK,    // system clock, 200 MHz
  input  wire logic              I_RESET,      // synchronous reset, active high
  input  wire logic [OCM_AW-1:0] I_ADDR,       // register address
  input  wire logic [OCM_DW-1:0] I_WDATA,      // register write data
  input  wire logic              I_WR,         // write strobe
  input  wire logic              I_RD,         // read strobe
  output logic      [OCM_DW-1:0] O_RDATA,      // read data, cycle after I_RD
  input  wire logic              I_KEY_UNLOCK, // security key accepted, level
  input  wire logic              I_OTP_FINAL,  // user pages finalised in the array
  input  wire logic              I_CMD_DONE,   // array or EEPROM finished a page, pulse
  input  wire logic              I_CMD_FAIL,   // page failed or mismatched, with I_CMD_DONE
  input  wire logic              I_AUTO_DONE,  // automatic programming finished, level
  output logic                   O_CMD_START,  // start one page operation, pulse
  output ocm_op_t                O_CMD_OP,     // operation of the page step
  output logic                   O_CMD_MEM,    // 1 OTP array, 0 external EEPROM
  output logic      [1:0]        O_CMD_MARGIN, // sense margin level
  output logic      [2:0]        O_CMD_PAGE,   // page of window and memory
  output logic                   O_PROG_STATE, // device in program state
  output logic                   O_MEM_IRQ     // primary memory interrupt
);

  ocm_state_t  state_reg;
  ocm_state_t  state_next;
  logic        prog_reg;
  logic        mem_reg;
  logic [1:0]  margin_reg;
  logic        bulk_reg;
  logic [1:0]  pgsel_reg;
  logic        done_reg;
  logic        fail_reg;
  logic [1:0]  mask_reg;
  logic        final_lock_reg;
  logic        auto_dly_reg;
  ocm_op_t     op_reg;
  logic        op_mem_reg;
  logic [1:0]  op_margin_reg;
  logic [2:0]  page_reg;
  logic [2:0]  last_reg;
  logic        start_reg;
  logic [15:0] rdata_reg;
  logic        irq_reg;

  wire wr_ctrl = I_WR && (I_ADDR == OCM_CTRL_ADDR);
  wire wr_stat = I_WR && (I_ADDR == OCM_STAT_ADDR);
  wire wr_mask = I_WR && (I_ADDR == OCM_MASK_ADDR);
  wire wr_key  = wr_ctrl && I_KEY_UNLOCK;
  wire [3:0] cmd_bits = {I_WDATA[OCM_FINAL_BIT], I_WDATA[OCM_VERIFY_BIT],
                         I_WDATA[OCM_WRITE_BIT], I_WDATA[OCM_READ_BIT]};
  wire cmd_one  = (cmd_bits != 4'h0) && ((cmd_bits & (cmd_bits - 4'h1)) == 4'h0);
  wire new_mem  = I_WDATA[OCM_MEM_BIT];
  wire new_bulk = I_WDATA[OCM_BULK_BIT];
  wire [1:0] new_pg = I_WDATA[OCM_PAGE_HI:OCM_PAGE_LO];
  // EEPROM supports read only, and its page code 11 has no page
  wire cmd_legal = new_mem ? 1'b1 : (I_WDATA[OCM_READ_BIT] && (new_bulk || new_pg != OCM_EE_RSVD_PAGE));
  wire idle = (state_reg == OCM_ST_IDLE);
  wire launch = wr_key && prog_reg && cmd_one && cmd_legal && idle;
  wire ocm_op_t new_op = I_WDATA[OCM_FINAL_BIT]  ? OCM_OP_FINAL  :
                         I_WDATA[OCM_VERIFY_BIT] ? OCM_OP_VERIFY :
                         I_WDATA[OCM_WRITE_BIT]  ? OCM_OP_WRITE  : OCM_OP_READ;
  wire [2:0] ee_page = {1'b0, new_pg} + OCM_EE_FIRST;
  wire [2:0] one_page = new_mem ? {1'b0, new_pg} : ee_page;
  wire [2:0] first_pg = !new_bulk ? one_page : (new_mem ? OCM_OTP_FIRST : OCM_EE_FIRST);
  wire [2:0] last_pg  = !new_bulk ? one_page : (new_mem ? OCM_OTP_LAST : OCM_EE_LAST);
  // factory pages are always finalised; user pages once the lock is set
  wire page_final = (page_reg < OCM_USER_FIRST) || final_lock_reg || I_OTP_FINAL;
  wire write_blocked = (op_reg == OCM_OP_WRITE) && page_final;
  wire step_done = (state_reg == OCM_ST_WAIT) && I_CMD_DONE;
  wire last_step = (page_reg == last_reg);
  wire fail_hit = (state_reg == OCM_ST_ISSUE && write_blocked) ||
                  (step_done && I_CMD_FAIL && ((op_reg == OCM_OP_VERIFY) ||
                  (op_reg == OCM_OP_READ && !op_mem_reg)));
  wire cmd_end = ((state_reg == OCM_ST_ISSUE && write_blocked) || step_done) && last_step;
  wire done_ev = cmd_end || (I_AUTO_DONE && !auto_dly_reg);
  wire [1:0] flag_clr = wr_stat ? {I_WDATA[OCM_DONE_BIT], I_WDATA[OCM_FAIL_BIT]} : 2'h0;
  wire done_next = done_ev || (done_reg && !flag_clr[1]);
  wire fail_next = fail_hit || (fail_reg && !flag_clr[0]);
  wire irq_next = (done_reg && !mask_reg[1]) || (fail_reg && !mask_reg[0]);
  wire [15:0] ctrl_rd = {prog_reg, 1'b0, mem_reg, 5'h00, margin_reg, bulk_reg, 3'h0, pgsel_reg};
  wire [15:0] stat_rd = {10'h000, done_reg, fail_reg, 3'h0, !idle};
  wire [15:0] mask_rd = {10'h000, mask_reg, 4'h0};
  wire [15:0] rd_mux = (I_ADDR == OCM_CTRL_ADDR) ? ctrl_rd :
                       (I_ADDR == OCM_STAT_ADDR) ? stat_rd :
                       (I_ADDR == OCM_MASK_ADDR) ? mask_rd : 16'h0000;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      OCM_ST_IDLE:  if (launch) state_next = OCM_ST_ISSUE;
      OCM_ST_ISSUE: if (write_blocked && last_step) state_next = OCM_ST_IDLE;
                    else if (!write_blocked) state_next = OCM_ST_WAIT;
      OCM_ST_WAIT:  if (I_CMD_DONE) state_next = last_step ? OCM_ST_IDLE : OCM_ST_ISSUE;
      default:      state_next = OCM_ST_IDLE;
    endcase
  end

  // software-visible control fields
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      prog_reg   <= 1'b0;
      mem_reg    <= OCM_CTRL_RST[OCM_MEM_BIT];
      margin_reg <= 2'h0;
      bulk_reg   <= 1'b0;
      pgsel_reg  <= 2'h0;
      mask_reg   <= OCM_MASK_RST;
    end else begin
      if (wr_key && I_WDATA[OCM_PROG_BIT]) begin
        prog_reg <= 1'b1;
      end
      if (wr_key) begin
        mem_reg    <= new_mem;
        margin_reg <= I_WDATA[OCM_MARGIN_HI:OCM_MARGIN_LO];
      end
      if (wr_ctrl) begin
        bulk_reg  <= new_bulk;
        pgsel_reg <= new_pg;
      end
      if (wr_mask) begin
        mask_reg <= {I_WDATA[OCM_DONE_BIT], I_WDATA[OCM_FAIL_BIT]};
      end
    end
  end

  // page sequencer toward the array / EEPROM
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      state_reg      <= OCM_ST_IDLE;
      op_reg         <= OCM_OP_READ;
      op_mem_reg     <= 1'b1;
      op_margin_reg  <= 2'h0;
      page_reg       <= 3'h0;
      last_reg       <= 3'h0;
      start_reg      <= 1'b0;
      final_lock_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      start_reg <= (state_reg == OCM_ST_ISSUE) && !write_blocked;
      if (launch) begin
        op_reg        <= new_op;
        op_mem_reg    <= new_mem;
        op_margin_reg <= I_WDATA[OCM_MARGIN_HI:OCM_MARGIN_LO];
        page_reg      <= first_pg;
        last_reg      <= last_pg;
      end else if (((state_reg == OCM_ST_ISSUE && write_blocked) || step_done) && !last_step) begin
        page_reg <= page_reg + 3'h1;
      end
      if (step_done && op_reg == OCM_OP_FINAL && !I_CMD_FAIL) begin
        final_lock_reg <= 1'b1;
      end
    end
  end

  // event flags, interrupt and read port
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      done_reg     <= 1'b0;
      fail_reg     <= 1'b0;
      // a level still high at release is old news, not a fresh completion
      auto_dly_reg <= 1'b1;
      irq_reg      <= 1'b0;
      rdata_reg    <= 16'h0000;
    end else begin
      done_reg     <= done_next;
      fail_reg     <= fail_next;
      auto_dly_reg <= I_AUTO_DONE;
      irq_reg      <= irq_next;
      rdata_reg    <= I_RD ? rd_mux : 16'h0000;
    end
  end

  assign O_RDATA      = rdata_reg;
  assign O_CMD_START  = start_reg;
  assign O_CMD_OP     = op_reg;
  assign O_CMD_MEM    = op_mem_reg;
  assign O_CMD_MARGIN = op_margin_reg;
  assign O_CMD_PAGE   = page_reg;
  assign O_PROG_STATE = prog_reg;
  assign O_MEM_IRQ    = irq_reg;

  // checks
  sequence key_prog_s;
    wr_ctrl && I_KEY_UNLOCK && I_WDATA[OCM_PROG_BIT];
  endsequence
  sequence locked_wr_s;
    wr_ctrl && !I_KEY_UNLOCK;
  endsequence

  prog_sticky_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    key_prog_s |=> prog_reg [*8])
    else $error("program state not held");
  key_guard_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    locked_wr_s |=> $stable(mem_reg) && $stable(margin_reg) && $stable(prog_reg))
    else $error("protected field changed while locked");
  launch_prog_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (wr_ctrl && idle && !prog_reg) |=> (state_reg == OCM_ST_IDLE))
    else $error("command launched outside program state");
  multi_cmd_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (wr_ctrl && idle && $countones(cmd_bits) > 1) |=> (state_reg == OCM_ST_IDLE))
    else $error("multiple command bits started an operation");
  page_map_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (launch && !new_mem && !new_bulk) |=> (page_reg == {1'b0, $past(new_pg)} + 3'h2))
    else $error("EEPROM page mapping wrong");
  final_write_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (state_reg == OCM_ST_ISSUE && write_blocked) |=> !start_reg && fail_reg)
    else $error("finalised page written or not failed");
  done_set_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    cmd_end |=> done_reg ##1 (done_reg || $past(flag_clr[1])))
    else $error("done flag not set at command end");
  w1c_clear_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (wr_stat && I_WDATA[OCM_FAIL_BIT] && !fail_hit) |=> !fail_reg)
    else $error("fail flag not cleared by write of one");
  irq_mask_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (done_reg && !mask_reg[1]) |=> O_MEM_IRQ)
    else $error("unmasked flag did not raise interrupt");
  mask_block_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (mask_reg == 2'h3) |=> !O_MEM_IRQ)
    else $error("masked flags raised interrupt");

  // page steps: a finished step that is not the last one must lead to
  // the next page two cycles later; writes are left out since they may skip
  sequence page_more_s;
    step_done && !last_step && op_reg != OCM_OP_WRITE;
  endsequence
  sequence page_next_s;
    O_CMD_START && (O_CMD_PAGE == $past(page_reg, 2) + 3'h1);
  endsequence
  sequence step_go_s;
    O_CMD_START;
  endsequence

  locked_cmd_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (wr_ctrl && !I_KEY_UNLOCK && idle) |=> (state_reg == OCM_ST_IDLE))
    else $error("command launched without key");
  route_sel_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    launch |=> (O_CMD_MEM == $past(new_mem)))
    else $error("memory select not routed to the page step");
  verify_cmd_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (launch && I_WDATA[OCM_VERIFY_BIT]) |=> (O_CMD_OP == OCM_OP_VERIFY) ##1 step_go_s)
    else $error("verify command not started");
  write_cmd_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (launch && I_WDATA[OCM_WRITE_BIT]) |=> (O_CMD_OP == OCM_OP_WRITE))
    else $error("write command not selected");
  read_cmd_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (launch && I_WDATA[OCM_READ_BIT]) |=> (O_CMD_OP == OCM_OP_READ) ##1 step_go_s)
    else $error("read command not started");
  final_cmd_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (launch && I_WDATA[OCM_FINAL_BIT]) |=> (O_CMD_OP == OCM_OP_FINAL) ##1 step_go_s)
    else $error("finalise command not started");
  locked_write_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (final_lock_reg && state_reg == OCM_ST_ISSUE && op_reg == OCM_OP_WRITE) |=> !O_CMD_START && fail_reg)
    else $error("write to finalised page performed");
  margin_pass_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    launch |=> (O_CMD_MARGIN == $past(I_WDATA[OCM_MARGIN_HI:OCM_MARGIN_LO])))
    else $error("margin level not passed on");
  bulk_first_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (launch && new_bulk) |=> (O_CMD_PAGE == ($past(new_mem) ? OCM_OTP_FIRST : OCM_EE_FIRST)))
    else $error("bulk run started on wrong page");
  bulk_next_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    page_more_s |-> ##2 page_next_s)
    else $error("bulk run did not move to next page");
  otp_page_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (launch && new_mem && !new_bulk) |=> (O_CMD_PAGE == {1'b0, $past(new_pg)}))
    else $error("OTP page mapping wrong");
  auto_done_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    ($rose(I_AUTO_DONE) && !$past(I_RESET)) |=> done_reg)
    else $error("automatic programming end not flagged");
  ee_fail_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (step_done && I_CMD_FAIL && op_reg == OCM_OP_READ && !op_mem_reg) |=> fail_reg)
    else $error("EEPROM read failure not flagged");
  fail_irq_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (fail_reg && !mask_reg[0]) |=> O_MEM_IRQ)
    else $error("unmasked fail flag did not raise interrupt");
  read_step_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (state_reg == OCM_ST_ISSUE && op_reg == OCM_OP_READ) |=> step_go_s)
    else $error("read page step not started");
  verify_fail_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    (step_done && I_CMD_FAIL && op_reg == OCM_OP_VERIFY) |=> fail_reg)
    else $error("verify mismatch not flagged");

endmodule

// ### src/ocm_pkg.sv
// shared constants for the nonvolatile memory command controller
package ocm_pkg;
  localparam int          OCM_AW           = 16;
  localparam int          OCM_DW           = 16;
  localparam logic [15:0] OCM_CTRL_ADDR    = 16'h400A;
  localparam logic [15:0] OCM_STAT_ADDR    = 16'h4012;
  localparam logic [15:0] OCM_MASK_ADDR    = 16'h401A;
  // control word fields
  localparam int          OCM_PROG_BIT     = 15;
  localparam int          OCM_MEM_BIT      = 13;
  localparam int          OCM_FINAL_BIT    = 11;
  localparam int          OCM_VERIFY_BIT   = 10;
  localparam int          OCM_WRITE_BIT    = 9;
  localparam int          OCM_READ_BIT     = 8;
  localparam int          OCM_MARGIN_HI    = 7;
  localparam int          OCM_MARGIN_LO    = 6;
  localparam int          OCM_BULK_BIT     = 5;
  localparam int          OCM_PAGE_HI      = 1;
  localparam int          OCM_PAGE_LO      = 0;
  // status and mask fields
  localparam int          OCM_DONE_BIT     = 5;
  localparam int          OCM_FAIL_BIT     = 4;
  localparam int          OCM_BUSY_BIT     = 0;
  localparam logic [15:0] OCM_CTRL_RST     = 16'h2000;
  localparam logic [1:0]  OCM_MASK_RST     = 2'h3;
  localparam logic [15:0] OCM_UNLOCK_CODE  = 16'h0000;
  // page ranges
  localparam logic [2:0]  OCM_OTP_FIRST    = 3'h0;
  localparam logic [2:0]  OCM_OTP_LAST     = 3'h3;
  localparam logic [2:0]  OCM_EE_FIRST     = 3'h2;
  localparam logic [2:0]  OCM_EE_LAST      = 3'h4;
  localparam logic [2:0]  OCM_USER_FIRST   = 3'h2;
  localparam logic [1:0]  OCM_EE_RSVD_PAGE = 2'h3;
  localparam logic [1:0]  OCM_MARGIN_RSVD  = 2'h1;
  typedef enum logic [1:0] {
    OCM_OP_READ   = 2'h0,
    OCM_OP_WRITE  = 2'h1,
    OCM_OP_VERIFY = 2'h2,
    OCM_OP_FINAL  = 2'h3
  } ocm_op_t;
  typedef enum logic [2:0] {
    OCM_ST_IDLE  = 3'b001,
    OCM_ST_ISSUE = 3'b010,
    OCM_ST_WAIT  = 3'b100
  } ocm_state_t;
endpackage

// ### sim/ocm_nvm_model.sv
// behavioural model of the OTP array and config EEPROM answering page steps
`timescale 1ns/10ps
module ocm_nvm_model
  import ocm_pkg::*;
(
  input  wire logic i_clk,     // system clock
  input  wire logic i_reset,   // synchronous reset, active high
  input  wire logic i_start,   // page step request, pulse
  input  wire logic i_fail_en, // answer every step as failed
  input  wire logic i_slow,    // answer after a long delay
  output logic      o_done,    // page step finished, pulse
  output logic      o_fail     // step failed, valid with o_done only
);
  logic [3:0] cnt_reg;
  logic       busy_reg;
  logic       junk_reg;
  // fail is only meaningful beside done, so it wiggles otherwise
  assign o_fail = o_done ? i_fail_en : junk_reg;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnt_reg  <= 4'h0;
      busy_reg <= 1'b0;
      o_done   <= 1'b0;
      junk_reg <= 1'b0;
    end else begin
      junk_reg <= ~junk_reg;
      o_done   <= 1'b0;
      if (i_start) begin
        busy_reg <= 1'b1;
        cnt_reg  <= i_slow ? 4'h6 : 4'h0;
      end else if (busy_reg && cnt_reg == 4'h0) begin
        busy_reg <= 1'b0;
        o_done   <= 1'b1;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end
endmodule

// ### sim/ocm_ctrl_test.sv
// self-checking bench for the memory command controller
`timescale 1ns/10ps
module ocm_ctrl_test
  import ocm_pkg::*;
;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, key = 0, fin = 0, adone = 0, fail_en = 0, slow = 0;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata, d;
  logic        start, mem, prog, irq, done, fail;
  logic [1:0]  mar;
  logic [2:0]  page;
  ocm_op_t     op;
  int          error_cnt = 0, samples_checked = 0, cyc = 0;
  logic [7:0]  q[$];

  always #2.5 clk = ~clk;
  always @(posedge clk) if (start) q.push_back({op, mem, mar, page});
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  ocm_ctrl i_dut (.I_SYS_CLK(clk), .I_RESET(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_KEY_UNLOCK(key), .I_OTP_FINAL(fin), .I_CMD_DONE(done), .I_CMD_FAIL(fail),
    .I_AUTO_DONE(adone), .O_CMD_START(start), .O_CMD_OP(op), .O_CMD_MEM(mem), .O_CMD_MARGIN(mar),
    .O_CMD_PAGE(page), .O_PROG_STATE(prog), .O_MEM_IRQ(irq));
  ocm_nvm_model i_mem (.i_clk(clk), .i_reset(rst), .i_start(start), .i_fail_en(fail_en), .i_slow(slow),
    .o_done(done), .o_fail(fail));

  task results;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      error_cnt++;
    end
  endtask
  task wreg(input logic [15:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= 1; addr <= a; wdata <= v;
    @(posedge clk);
    wr <= 0;
  endtask
  task rreg(input logic [15:0] a, output logic [15:0] v);
    @(posedge clk);
    rd <= 1; addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 v = rdata;
  endtask
  task rchk(input string n, input logic [15:0] a, input logic [15:0] e);
    rreg(a, d);
    chk(n, d, e);
  endtask
  task ichk(input logic e);
    repeat (3) @(posedge clk);
    #1 chk("irq", {15'h0, irq}, {15'h0, e});
  endtask
  // flags are cleared first so a finished run leaves its flags for the irq tests
  task cmd(input logic [15:0] v, input int n, input logic [7:0] first, input logic [15:0] st);
    int i;
    wreg(OCM_STAT_ADDR, 16'h0030);
    q.delete();
    wreg(OCM_CTRL_ADDR, v);
    repeat (2) @(posedge clk);
    for (i = 0; i < 100; i++) begin
      rreg(OCM_STAT_ADDR, d);
      if (d[OCM_BUSY_BIT] === 1'b0) break;
    end
    repeat (2) @(posedge clk);
    chk("starts", 16'(q.size()), 16'(n));
    foreach (q[k]) chk("step", {8'h00, q[k]}, {8'h00, first + 8'(k)});
    rchk("status", OCM_STAT_ADDR, st);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    rchk("ctrl", OCM_CTRL_ADDR, OCM_CTRL_RST);
    rchk("mask", OCM_MASK_ADDR, 16'h0030);
    rchk("stat", OCM_STAT_ADDR, 16'h0000);
    rchk("unmapped", 16'h4000, 16'h0000);
    wreg(OCM_CTRL_ADDR, 16'h8123);
    rchk("ctrl", OCM_CTRL_ADDR, 16'h2023);
    chk("prog", {15'h0, prog}, 16'h0000);
    @(posedge clk);
    key <= 1;
    cmd(16'h2202, 0, 8'h00, 16'h0000);
    wreg(OCM_CTRL_ADDR, 16'h8000);
    wreg(OCM_CTRL_ADDR, 16'h0000);
    #1 chk("prog", {15'h0, prog}, 16'h0001);
    $display("test key and program state done");
    cmd(16'h2202, 1, {OCM_OP_WRITE, 1'b1, 2'h0, 3'h2}, 16'h0020);
    @(posedge clk);
    slow <= 1;
    cmd(16'h0120, 3, {OCM_OP_READ, 1'b0, 2'h0, 3'h2}, 16'h0020);
    cmd(16'h2120, 4, {OCM_OP_READ, 1'b1, 2'h0, 3'h0}, 16'h0020);
    @(posedge clk);
    slow <= 0;
    cmd(16'h0101, 1, {OCM_OP_READ, 1'b0, 2'h0, 3'h3}, 16'h0020);
    cmd(16'h0103, 0, 8'h00, 16'h0000);
    cmd(16'h0202, 0, 8'h00, 16'h0000);
    cmd(16'h2300, 0, 8'h00, 16'h0000);
    cmd(16'h2401, 1, {OCM_OP_VERIFY, 1'b1, 2'h0, 3'h1}, 16'h0020);
    cmd(16'h2482, 1, {OCM_OP_VERIFY, 1'b1, 2'h2, 3'h2}, 16'h0020);
    $display("test commands done");
    @(posedge clk);
    fail_en <= 1;
    cmd(16'h0100, 1, {OCM_OP_READ, 1'b0, 2'h0, 3'h2}, 16'h0030);
    cmd(16'h24C3, 1, {OCM_OP_VERIFY, 1'b1, 2'h3, 3'h3}, 16'h0030);
    @(posedge clk);
    fail_en <= 0;
    ichk(1'b0);
    wreg(OCM_MASK_ADDR, 16'h0020);
    ichk(1'b1);
    wreg(OCM_STAT_ADDR, 16'h0010);
    ichk(1'b0);
    rchk("stat", OCM_STAT_ADDR, 16'h0020);
    wreg(OCM_MASK_ADDR, 16'h0010);
    rchk("mask", OCM_MASK_ADDR, 16'h0010);
    ichk(1'b1);
    wreg(OCM_STAT_ADDR, 16'h0020);
    ichk(1'b0);
    @(posedge clk);
    adone <= 1;
    ichk(1'b1);
    rchk("stat", OCM_STAT_ADDR, 16'h0020);
    $display("test flags done");
    cmd(16'h2200, 0, 8'h00, 16'h0030);
    // bulk write skips the factory pages with a failure and programs 2 and 3
    cmd(16'h2220, 2, {OCM_OP_WRITE, 1'b1, 2'h0, 3'h2}, 16'h0030);
    cmd(16'h2802, 1, {OCM_OP_FINAL, 1'b1, 2'h0, 3'h2}, 16'h0020);
    cmd(16'h2203, 0, 8'h00, 16'h0030);
    @(posedge clk);
    rst <= 1;
    repeat (5) @(posedge clk);
    rst <= 0;
    fin <= 1;
    #1 chk("prog", {15'h0, prog}, 16'h0000);
    rchk("ctrl", OCM_CTRL_ADDR, OCM_CTRL_RST);
    // auto-done is still high across the reset and must not flag again
    rchk("stat", OCM_STAT_ADDR, 16'h0000);
    wreg(OCM_CTRL_ADDR, 16'h8000);
    cmd(16'h2202, 0, 8'h00, 16'h0030);
    $display("test finalise and second reset done");
    results();
  end
endmodule
